// ===== design/mirp_defs.vh
`ifndef MIRP_DEFS_VH
`define MIRP_DEFS_VH

// Special function register addresses
`define MIRP_SFR_PTR        8'h91
`define MIRP_SFR_DAT_L      8'h92
`define MIRP_SFR_DAT_M      8'h93
`define MIRP_SFR_DAT_H      8'h94
`define MIRP_SFR_VRMS_L     8'hd1
`define MIRP_SFR_VRMS_M     8'hd2
`define MIRP_SFR_VRMS_H     8'hd3
`define MIRP_SFR_IRMS_L     8'hd4
`define MIRP_SFR_IRMS_M     8'hd5
`define MIRP_SFR_IRMS_H     8'hd6
`define MIRP_SFR_IEN_L      8'hd9
`define MIRP_SFR_IEN_M      8'hda
`define MIRP_SFR_IEN_H      8'hdb
`define MIRP_SFR_IST_L      8'hdc
`define MIRP_SFR_IST_M      8'hdd
`define MIRP_SFR_IST_H      8'hde
`define MIRP_SFR_WAV1_L     8'he2
`define MIRP_SFR_WAV1_M     8'he3
`define MIRP_SFR_WAV1_H     8'he4
`define MIRP_SFR_WAV2_L     8'he5
`define MIRP_SFR_WAV2_M     8'he6
`define MIRP_SFR_WAV2_H     8'he7

// Pointer fields
`define MIRP_PTR_DIR_BIT    7
`define MIRP_PTR_ADDR_MSB   6

// Internal register addresses
`define MIRP_IR_ACT         7'h01
`define MIRP_IR_ACT_CLR     7'h02
`define MIRP_IR_ACT_LINE    7'h03
`define MIRP_IR_REA         7'h04
`define MIRP_IR_REA_CLR     7'h05
`define MIRP_IR_REA_LINE    7'h06
`define MIRP_IR_APP         7'h07
`define MIRP_IR_APP_CLR     7'h08
`define MIRP_IR_APP_LINE    7'h09
`define MIRP_IR_PERIOD      7'h0a
`define MIRP_IR_CFG_A       7'h0b
`define MIRP_IR_CFG_B       7'h0c
`define MIRP_IR_WAVSEL      7'h0d
`define MIRP_IR_NOLOAD      7'h0e
`define MIRP_IR_ACCCFG      7'h0f
`define MIRP_IR_PHASE_CALIBRATION       7'h10
`define MIRP_IR_ZERO_CROSS_TIMEOUT      7'h11

// Reset values
`define MIRP_RST_CFG_A      8'h06
`define MIRP_RST_CFG_B      8'h40
`define MIRP_RST_WAVSEL     8'h00
`define MIRP_RST_NOLOAD     8'h00
`define MIRP_RST_ACCCFG     8'h00
`define MIRP_RST_PHASE_CALIBRATION      8'h40
`define MIRP_RST_ZERO_CROSS_TIMEOUT     12'hfff

// Field positions in metering_config_b
`define MIRP_CFGB_APP_IRMS  3
`define MIRP_CFGB_FREQ_SEL  0

// Timing: metering clock is reference divided by five
`define MIRP_REF_KHZ        4096
`define MIRP_METER_DIV      5
`define MIRP_CLK_KHZ        250000
`define MIRP_METER_CYCLES   ((`MIRP_CLK_KHZ * `MIRP_METER_DIV) / `MIRP_REF_KHZ)

`endif

// ===== design/mirp_top.v
`include "mirp_defs.vh"

module mirp_top #(
  parameter METER_CYCLES = `MIRP_METER_CYCLES
) (
  input  wire        ref_clk,
  input  wire        nrst,
  input  wire        ce,
  input  wire [7:0]  sfr_addr,
  input  wire [7:0]  sfr_wdata,
  input  wire        sfr_wr,
  input  wire        sfr_rd,
  input  wire [23:0] active_pwr_in,
  input  wire [23:0] reactive_pwr_in,
  input  wire [23:0] apparent_pwr_in,
  input  wire [23:0] irms_in,
  input  wire [23:0] vrms_in,
  input  wire [23:0] wave1_in,
  input  wire [23:0] wave2_in,
  input  wire [15:0] line_period_in,
  input  wire [15:0] line_freq_in,
  input  wire        line_cycle_end,
  input  wire [23:0] irq_event_in,
  output reg  [7:0]  sfr_rdata_ff,
  output reg         xfer_busy_ff,
  output reg         meter_tick_ff,
  output reg  [7:0]  cfg_a_ff,
  output reg  [7:0]  cfg_b_ff,
  output reg  [7:0]  wavsel_ff,
  output reg  [7:0]  noload_ff,
  output reg  [7:0]  acccfg_ff,
  output reg  [7:0]  phase_calibration_ff,
  output reg  [11:0] zero_cross_timeout_ff
);

  // Register byte of a 24-bit word picked by the low address bits
  function [7:0] mirp_byte;
    input [23:0] word;
    input [1:0]  sel;
    begin
      case (sel)
        2'h0:    mirp_byte = word[7:0];
        2'h1:    mirp_byte = word[15:8];
        default: mirp_byte = word[23:16];
      endcase
    end
  endfunction

  // Cut to the counter width on purpose; the default count fits in nine bits
  localparam integer TICK_FULL = METER_CYCLES - 1;
  localparam [8:0]   TICK_MAX  = TICK_FULL[8:0];

  reg  [8:0]  tick_cnt_ff;
  reg  [7:0]  ptr_ff;
  reg  [7:0]  dat_l_ff;
  reg  [7:0]  dat_m_ff;
  reg  [7:0]  dat_h_ff;
  reg  [7:0]  xptr_ff;
  reg  [23:0] xdat_ff;
  reg  [23:0] act_acc_ff;
  reg  [23:0] rea_acc_ff;
  reg  [23:0] app_acc_ff;
  reg  [23:0] act_run_ff;
  reg  [23:0] rea_run_ff;
  reg  [23:0] app_run_ff;
  reg  [23:0] act_line_ff;
  reg  [23:0] rea_line_ff;
  reg  [23:0] app_line_ff;
  reg  [23:0] vrms_lat_ff;
  reg  [23:0] irms_lat_ff;
  reg  [23:0] wav1_lat_ff;
  reg  [23:0] wav2_lat_ff;
  reg  [23:0] ien_ff;
  reg  [23:0] ist_live_ff;
  reg  [23:0] ist_lat_ff;
  reg  [23:0] nxt_rd_word;
  reg  [1:0]  nxt_rd_len;
  reg  [7:0]  nxt_rdata;

  wire        wr_ptr   = ce & sfr_wr & (sfr_addr == `MIRP_SFR_PTR);
  wire        tick     = ce & (tick_cnt_ff == TICK_MAX);
  wire        do_xfer  = tick & xfer_busy_ff;
  wire        xfer_wr  = xptr_ff[`MIRP_PTR_DIR_BIT];
  wire [6:0]  xaddr    = xptr_ff[`MIRP_PTR_ADDR_MSB:0];
  wire        xfer_rd  = do_xfer & ~xfer_wr;
  wire [23:0] app_src  = cfg_b_ff[`MIRP_CFGB_APP_IRMS] ? irms_in : apparent_pwr_in;
  wire [23:0] ist_clr  = (ce & sfr_wr) ? {(sfr_addr == `MIRP_SFR_IST_H) ? sfr_wdata : 8'h00,
                                          (sfr_addr == `MIRP_SFR_IST_M) ? sfr_wdata : 8'h00,
                                          (sfr_addr == `MIRP_SFR_IST_L) ? sfr_wdata : 8'h00} : 24'h000000;
  wire [23:0] wav1_src = wavsel_ff[0] ? irms_in : wave1_in;
  wire [23:0] wav2_src = wavsel_ff[1] ? vrms_in : wave2_in;

  // Metering clock tick: reference divided by five, in processor cycles
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tick_cnt_ff   <= 9'h000;
      meter_tick_ff <= 1'b0;
    end else if (ce) begin
      tick_cnt_ff   <= (tick_cnt_ff == TICK_MAX) ? 9'h000 : tick_cnt_ff + 9'h001;
      meter_tick_ff <= (tick_cnt_ff == TICK_MAX);
    end
  end

  // Internal register read mux with byte length of each register
  always @* begin
    nxt_rd_word = 24'h000000;
    nxt_rd_len  = 2'h1;
    case (xaddr)
      `MIRP_IR_ACT, `MIRP_IR_ACT_CLR: begin
        nxt_rd_word = act_acc_ff;
        nxt_rd_len  = 2'h3;
      end
      `MIRP_IR_ACT_LINE: begin
        nxt_rd_word = act_line_ff;
        nxt_rd_len  = 2'h3;
      end
      `MIRP_IR_REA, `MIRP_IR_REA_CLR: begin
        nxt_rd_word = rea_acc_ff;
        nxt_rd_len  = 2'h3;
      end
      `MIRP_IR_REA_LINE: begin
        nxt_rd_word = rea_line_ff;
        nxt_rd_len  = 2'h3;
      end
      `MIRP_IR_APP, `MIRP_IR_APP_CLR: begin
        nxt_rd_word = app_acc_ff;
        nxt_rd_len  = 2'h3;
      end
      `MIRP_IR_APP_LINE: begin
        nxt_rd_word = app_line_ff;
        nxt_rd_len  = 2'h3;
      end
      `MIRP_IR_PERIOD: begin
        nxt_rd_word = {8'h00, cfg_b_ff[`MIRP_CFGB_FREQ_SEL] ? line_freq_in : line_period_in};
        nxt_rd_len  = 2'h2;
      end
      `MIRP_IR_CFG_A:  nxt_rd_word = {16'h0000, cfg_a_ff};
      `MIRP_IR_CFG_B:  nxt_rd_word = {16'h0000, cfg_b_ff};
      `MIRP_IR_WAVSEL: nxt_rd_word = {16'h0000, wavsel_ff};
      `MIRP_IR_NOLOAD: nxt_rd_word = {16'h0000, noload_ff};
      `MIRP_IR_ACCCFG: nxt_rd_word = {16'h0000, acccfg_ff};
      `MIRP_IR_PHASE_CALIBRATION:  nxt_rd_word = {16'h0000, phase_calibration_ff};
      `MIRP_IR_ZERO_CROSS_TIMEOUT: begin
        nxt_rd_word = {12'h000, zero_cross_timeout_ff};
        nxt_rd_len  = 2'h2;
      end
      default:         nxt_rd_word = 24'h000000;
    endcase
  end

  // Pointer write snapshots pointer and data so later byte writes cannot disturb it
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ptr_ff       <= 8'h00;
      xptr_ff      <= 8'h00;
      xdat_ff      <= 24'h000000;
      xfer_busy_ff <= 1'b0;
    end else if (ce) begin
      if (wr_ptr) begin
        ptr_ff       <= sfr_wdata;
        xptr_ff      <= sfr_wdata;
        xdat_ff      <= {dat_h_ff, dat_m_ff, dat_l_ff};
        xfer_busy_ff <= 1'b1;
      end else if (do_xfer) begin
        xfer_busy_ff <= 1'b0;
      end
    end
  end

  // Data bytes: written by software, overwritten by a completed read transfer
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dat_l_ff <= 8'h00;
      dat_m_ff <= 8'h00;
      dat_h_ff <= 8'h00;
    end else if (ce) begin
      if (xfer_rd) begin
        dat_l_ff <= nxt_rd_word[7:0];
        dat_m_ff <= (nxt_rd_len == 2'h1) ? 8'h00 : nxt_rd_word[15:8];
        dat_h_ff <= (nxt_rd_len == 2'h3) ? nxt_rd_word[23:16] : 8'h00;
      end else if (sfr_wr) begin
        if (sfr_addr == `MIRP_SFR_DAT_L)
          dat_l_ff <= sfr_wdata;
        if (sfr_addr == `MIRP_SFR_DAT_M)
          dat_m_ff <= sfr_wdata;
        if (sfr_addr == `MIRP_SFR_DAT_H)
          dat_h_ff <= sfr_wdata;
      end
    end
  end

  // Configuration registers, written only at a metering tick
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cfg_a_ff  <= `MIRP_RST_CFG_A;
      cfg_b_ff  <= `MIRP_RST_CFG_B;
      wavsel_ff <= `MIRP_RST_WAVSEL;
      noload_ff <= `MIRP_RST_NOLOAD;
      acccfg_ff <= `MIRP_RST_ACCCFG;
      phase_calibration_ff  <= `MIRP_RST_PHASE_CALIBRATION;
      zero_cross_timeout_ff <= `MIRP_RST_ZERO_CROSS_TIMEOUT;
    end else if (do_xfer && xfer_wr) begin
      // One-byte targets take only the low data byte
      case (xaddr)
        `MIRP_IR_CFG_A:  cfg_a_ff  <= xdat_ff[7:0];
        `MIRP_IR_CFG_B:  cfg_b_ff  <= xdat_ff[7:0];
        `MIRP_IR_WAVSEL: wavsel_ff <= xdat_ff[7:0];
        `MIRP_IR_NOLOAD: noload_ff <= xdat_ff[7:0];
        `MIRP_IR_ACCCFG: acccfg_ff <= xdat_ff[7:0];
        `MIRP_IR_PHASE_CALIBRATION:  phase_calibration_ff  <= xdat_ff[7:0];
        `MIRP_IR_ZERO_CROSS_TIMEOUT: zero_cross_timeout_ff <= xdat_ff[11:0];
        default:         zero_cross_timeout_ff <= zero_cross_timeout_ff;
      endcase
    end
  end

  // Energy accumulators advance on each metering tick; clearing read restarts them
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      act_acc_ff  <= 24'h000000;
      rea_acc_ff  <= 24'h000000;
      app_acc_ff  <= 24'h000000;
      act_run_ff  <= 24'h000000;
      rea_run_ff  <= 24'h000000;
      app_run_ff  <= 24'h000000;
      act_line_ff <= 24'h000000;
      rea_line_ff <= 24'h000000;
      app_line_ff <= 24'h000000;
    end else if (tick) begin
      // A clearing read drops this tick's sample; the value read is what the reader saw
      act_acc_ff <= (xfer_rd && xaddr == `MIRP_IR_ACT_CLR) ? 24'h000000 : act_acc_ff + active_pwr_in;
      rea_acc_ff <= (xfer_rd && xaddr == `MIRP_IR_REA_CLR) ? 24'h000000 : rea_acc_ff + reactive_pwr_in;
      app_acc_ff <= (xfer_rd && xaddr == `MIRP_IR_APP_CLR) ? 24'h000000 : app_acc_ff + app_src;
      // Line-synchronous copies take the sum over a finished line period
      if (line_cycle_end) begin
        act_line_ff <= act_run_ff + active_pwr_in;
        rea_line_ff <= rea_run_ff + reactive_pwr_in;
        app_line_ff <= app_run_ff + app_src;
        act_run_ff  <= 24'h000000;
        rea_run_ff  <= 24'h000000;
        app_run_ff  <= 24'h000000;
      end else begin
        act_run_ff  <= act_run_ff + active_pwr_in;
        rea_run_ff  <= rea_run_ff + reactive_pwr_in;
        app_run_ff  <= app_run_ff + app_src;
      end
    end
  end

  // Three-byte direct values latch whole on a high-byte read
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      vrms_lat_ff <= 24'h000000;
      irms_lat_ff <= 24'h000000;
      wav1_lat_ff <= 24'h000000;
      wav2_lat_ff <= 24'h000000;
    end else if (ce && sfr_rd) begin
      if (sfr_addr == `MIRP_SFR_VRMS_H)
        vrms_lat_ff <= vrms_in;
      if (sfr_addr == `MIRP_SFR_IRMS_H)
        irms_lat_ff <= irms_in;
      if (sfr_addr == `MIRP_SFR_WAV1_H)
        wav1_lat_ff <= wav1_src;
      if (sfr_addr == `MIRP_SFR_WAV2_H)
        wav2_lat_ff <= wav2_src;
    end
  end

  // Interrupt enable and status; a new event wins over a clear in the same cycle
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ien_ff      <= 24'h000000;
      ist_live_ff <= 24'h000000;
      ist_lat_ff  <= 24'h000000;
    end else if (ce) begin
      ist_live_ff <= (ist_live_ff & ~ist_clr) | irq_event_in;
      if (sfr_wr && sfr_addr == `MIRP_SFR_IEN_L)
        ien_ff[7:0] <= sfr_wdata;
      if (sfr_wr && sfr_addr == `MIRP_SFR_IEN_M)
        ien_ff[15:8] <= sfr_wdata;
      if (sfr_wr && sfr_addr == `MIRP_SFR_IEN_H)
        ien_ff[23:16] <= sfr_wdata;
      if (sfr_rd && sfr_addr == `MIRP_SFR_IST_L)
        ist_lat_ff[7:0] <= ist_live_ff[7:0];
      if (sfr_rd && sfr_addr == `MIRP_SFR_IST_M)
        ist_lat_ff[15:8] <= ist_live_ff[15:8];
      if (sfr_rd && sfr_addr == `MIRP_SFR_IST_H)
        ist_lat_ff[23:16] <= ist_live_ff[23:16];
    end
  end

  // Read data mux; high bytes return the value being latched in the same cycle
  always @* begin
    case (sfr_addr)
      `MIRP_SFR_PTR:    nxt_rdata = ptr_ff;
      `MIRP_SFR_DAT_L:  nxt_rdata = dat_l_ff;
      `MIRP_SFR_DAT_M:  nxt_rdata = dat_m_ff;
      `MIRP_SFR_DAT_H:  nxt_rdata = dat_h_ff;
      `MIRP_SFR_VRMS_L, `MIRP_SFR_VRMS_M: nxt_rdata = mirp_byte(vrms_lat_ff, sfr_addr[1:0] - 2'h1);
      `MIRP_SFR_VRMS_H: nxt_rdata = vrms_in[23:16];
      `MIRP_SFR_IRMS_L: nxt_rdata = irms_lat_ff[7:0];
      `MIRP_SFR_IRMS_M: nxt_rdata = irms_lat_ff[15:8];
      `MIRP_SFR_IRMS_H: nxt_rdata = irms_in[23:16];
      `MIRP_SFR_IEN_L, `MIRP_SFR_IEN_M, `MIRP_SFR_IEN_H:
                        nxt_rdata = mirp_byte(ien_ff, sfr_addr[1:0] - 2'h1);
      `MIRP_SFR_IST_L:  nxt_rdata = ist_live_ff[7:0];
      `MIRP_SFR_IST_M:  nxt_rdata = ist_live_ff[15:8];
      `MIRP_SFR_IST_H:  nxt_rdata = ist_live_ff[23:16];
      `MIRP_SFR_WAV1_L: nxt_rdata = wav1_lat_ff[7:0];
      `MIRP_SFR_WAV1_M: nxt_rdata = wav1_lat_ff[15:8];
      `MIRP_SFR_WAV1_H: nxt_rdata = wav1_src[23:16];
      `MIRP_SFR_WAV2_L: nxt_rdata = wav2_lat_ff[7:0];
      `MIRP_SFR_WAV2_M: nxt_rdata = wav2_lat_ff[15:8];
      `MIRP_SFR_WAV2_H: nxt_rdata = wav2_src[23:16];
      default:          nxt_rdata = 8'h00;
    endcase
  end

  // Registered read data; holds until the next read
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst)
      sfr_rdata_ff <= 8'h00;
    else if (ce && sfr_rd)
      sfr_rdata_ff <= nxt_rdata;
  end

endmodule // mirp_top

// ===== tb/mirp_meter_src.sv
module mirp_meter_src (
  input  wire         alt,
  output logic [23:0] act,
  output logic [23:0] rea,
  output logic [23:0] app,
  output logic [23:0] irms,
  output logic [23:0] vrms,
  output logic [23:0] wave1,
  output logic [23:0] wave2,
  output logic [15:0] period,
  output logic [15:0] freq
);
  timeunit 1ns;
  timeprecision 1ps;
  // Fixed live values make sums easy to predict; vrms switches so a stale latch shows
  assign act    = 24'h000010;
  assign rea    = 24'hfffff0;
  assign app    = 24'h000020;
  assign irms   = 24'h123456;
  assign vrms   = alt ? 24'h13579b : 24'h654321;
  assign wave1  = 24'habcdef;
  assign wave2  = 24'h0a0b0c;
  assign period = 16'h1234;
  assign freq   = 16'h0032;
endmodule // mirp_meter_src

// ===== tb/mirp_monitor.sv
module mirp_monitor #(
  parameter METER_CYCLES = 305
) (
  input wire        ref_clk,
  input wire        nrst,
  input wire        ce,
  input wire [7:0]  sfr_addr,
  input wire        sfr_wr,
  input wire        sfr_rd,
  input wire [23:0] vrms_in,
  input wire [23:0] irms_in,
  input wire [7:0]  sfr_rdata_ff,
  input wire        xfer_busy_ff,
  input wire        meter_tick_ff,
  input wire [7:0]  cfg_a_ff,
  input wire [11:0] zero_cross_timeout_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  logic [15:0] gap_cnt_ff;
  logic        seen_ff;
  logic [7:0]  vrms_hi_ff;
  logic [7:0]  irms_hi_ff;
  wire         rd_go = ce && sfr_rd;
  wire         ptr_wr = ce && sfr_wr && (sfr_addr == 8'h91);
  // Gap since last tick; the first gap after reset counts one cycle more, so it is skipped
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      gap_cnt_ff <= 16'h0000;
      seen_ff    <= 1'b0;
    end else if (meter_tick_ff) begin
      gap_cnt_ff <= 16'h0000;
      seen_ff    <= 1'b1;
    end else if (ce) begin
      gap_cnt_ff <= gap_cnt_ff + 16'h0001;
    end
  end
  // Live high bytes one cycle late, to line up with registered read data
  always_ff @(posedge ref_clk) begin
    vrms_hi_ff <= vrms_in[23:16];
    irms_hi_ff <= irms_in[23:16];
  end
  sequence s_irms_hi;
    rd_go && (sfr_addr == 8'hd6);
  endsequence
  AST_BUSY_SET: assert property (ptr_wr |=> xfer_busy_ff) else $error("busy missing");
  AST_BUSY_BOUND: assert property ($rose(xfer_busy_ff) |-> ##[1:400] !xfer_busy_ff) else $error("busy stuck");
  AST_BUSY_END: assert property ($fell(xfer_busy_ff) |-> $past(meter_tick_ff) || meter_tick_ff)
    else $error("busy fell off tick");
  AST_TICK_PULSE: assert property (meter_tick_ff && ce |=> !meter_tick_ff) else $error("tick long");
  AST_TICK_GAP: assert property (meter_tick_ff && seen_ff |-> gap_cnt_ff == METER_CYCLES - 1)
    else $error("tick period");
  AST_RD_HOLD: assert property (!rd_go |=> $stable(sfr_rdata_ff)) else $error("rdata moved");
  AST_UNMAPPED: assert property (rd_go && sfr_addr == 8'h95 |=> sfr_rdata_ff == 8'h00) else $error("unmapped");
  AST_VRMS_LATCH: assert property (rd_go && sfr_addr == 8'hd3 |=> sfr_rdata_ff == vrms_hi_ff)
    else $error("vrms high");
  AST_IRMS_LATCH: assert property (s_irms_hi |=> sfr_rdata_ff == irms_hi_ff) else $error("irms high");
  AST_CFG_XFER: assert property ((!$stable(cfg_a_ff) || !$stable(zero_cross_timeout_ff)) |-> $past(xfer_busy_ff))
    else $error("config moved idle");
  cover property (ptr_wr ##1 xfer_busy_ff);
  cover property (rd_go && sfr_addr == 8'hd3);
  cover property ($fell(xfer_busy_ff));
endmodule // mirp_monitor

bind mirp_top mirp_monitor #(.METER_CYCLES(METER_CYCLES)) i_mirp_monitor (
  .ref_clk(ref_clk), .nrst(nrst), .ce(ce), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
  .vrms_in(vrms_in), .irms_in(irms_in), .sfr_rdata_ff(sfr_rdata_ff), .xfer_busy_ff(xfer_busy_ff),
  .meter_tick_ff(meter_tick_ff), .cfg_a_ff(cfg_a_ff), .zero_cross_timeout_ff(zero_cross_timeout_ff));

// ===== tb/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MC = 24;
  logic        ref_clk = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  sfr_addr = 8'h00;
  logic [7:0]  sfr_wdata = 8'h00;
  logic        sfr_wr = 1'b0;
  logic        sfr_rd = 1'b0;
  logic        line_cycle_end = 1'b0;
  logic [23:0] irq_event = 24'h000000;
  logic        alt = 1'b0;
  wire  [23:0] act, rea, app, irms, vrms, wave1, wave2;
  wire  [15:0] period, freq;
  wire  [7:0]  sfr_rdata_ff, cfg_a_ff;
  wire  [11:0] zero_cross_timeout_ff;
  wire         xfer_busy_ff, meter_tick_ff;
  int          fail_count = 0;
  int          tests_run = 0;
  int          cyc = 0;
  logic [23:0] got;

  mirp_meter_src i_mirp_meter_src (.alt(alt), .act(act), .rea(rea), .app(app), .irms(irms), .vrms(vrms),
    .wave1(wave1), .wave2(wave2), .period(period), .freq(freq));
  mirp_top #(.METER_CYCLES(MC)) i_mirp_top (.ref_clk(ref_clk), .nrst(nrst), .ce(1'b1), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .active_pwr_in(act), .reactive_pwr_in(rea),
    .apparent_pwr_in(app), .irms_in(irms), .vrms_in(vrms), .wave1_in(wave1), .wave2_in(wave2),
    .line_period_in(period), .line_freq_in(freq), .line_cycle_end(line_cycle_end), .irq_event_in(irq_event),
    .sfr_rdata_ff(sfr_rdata_ff), .xfer_busy_ff(xfer_busy_ff), .meter_tick_ff(meter_tick_ff),
    .cfg_a_ff(cfg_a_ff), .cfg_b_ff(), .wavsel_ff(), .noload_ff(), .acccfg_ff(), .phase_calibration_ff(),
    .zero_cross_timeout_ff(zero_cross_timeout_ff));

  // Clock at 250 MHz
  always #2 ref_clk = ~ref_clk;

  task automatic print_verdict();
    $display("checks %0d errors %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input string nm, input logic [23:0] exp, input logic [23:0] seen);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Strobes rise and fall on falling edges, so each is taken at exactly one rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge ref_clk);
    sfr_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge ref_clk);
    sfr_rd = 1'b0;
    d = sfr_rdata_ff;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    check($sformatf("sfr %h", a), {16'h0000, exp}, {16'h0000, d});
  endtask

  // Software waits on busy before touching the data bytes; bounded in case it never drops
  task automatic wait_done();
    int n;
    n = 0;
    while (xfer_busy_ff !== 1'b0 && n < 4 * MC) begin
      @(negedge ref_clk);
      n++;
    end
    check("xfer_busy_ff", 24'h000000, {23'h0, xfer_busy_ff});
  endtask

  // Optional poke writes the low data byte mid-transfer; the read result must still win
  task automatic ind_rd(input logic [6:0] a, input logic poke, output logic [23:0] v);
    // A poke starts just after a tick so the transfer cannot finish before it lands
    if (poke) @(posedge meter_tick_ff);
    wr(8'h91, {1'b0, a});
    check("xfer_busy_ff", 24'h000001, {23'h0, xfer_busy_ff});
    if (poke) wr(8'h92, 8'hee);
    wait_done();
    rd(8'h94, v[23:16]);
    rd(8'h93, v[15:8]);
    rd(8'h92, v[7:0]);
  endtask

  task automatic ind_chk(input logic [6:0] a, input logic [23:0] exp, input logic poke = 1'b0);
    ind_rd(a, poke, got);
    check($sformatf("reg %h", a), exp, got);
  endtask

  task automatic ind_wr(input logic [6:0] a, input logic [23:0] v);
    wr(8'h92, v[7:0]);
    wr(8'h93, v[15:8]);
    wr(8'h94, v[23:16]);
    wr(8'h91, {1'b1, a});
    wait_done();
  endtask

  // A hung handshake is cut short well past the expected run length
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      $display("[ERR] run length expected under 20000 seen 20000");
      print_verdict();
    end
  end

  // Main sequence; energy clears run on consecutive ticks so the sums are exact
  initial begin
    repeat (4) @(negedge ref_clk);
    nrst = 1'b1;
    rd_chk(8'he4, 8'hab);
    rd_chk(8'he7, 8'h0a);
    ind_chk(7'h0b, 24'h000006);
    ind_chk(7'h0c, 24'h000040);
    ind_chk(7'h0d, 24'h000000);
    ind_chk(7'h0e, 24'h000000);
    ind_chk(7'h0f, 24'h000000);
    ind_chk(7'h10, 24'h000040);
    ind_chk(7'h11, 24'h000fff);
    ind_wr(7'h0b, 24'hffff5a);
    check("cfg_a_ff", 24'h00005a, {16'h0, cfg_a_ff});
    ind_chk(7'h0b, 24'h00005a, 1'b1);
    ind_wr(7'h11, 24'h012abc);
    check("zero_cross_timeout_ff", 24'h000abc, {12'h0, zero_cross_timeout_ff});
    ind_chk(7'h11, 24'h000abc);
    rd_chk(8'h91, 8'h11);
    ind_wr(7'h0d, 24'h000003);
    ind_wr(7'h0c, 24'h000048);
    ind_chk(7'h0a, 24'h001234);
    // A clearing read on the very next tick sees the zero left by the previous one
    ind_rd(7'h02, 1'b0, got);
    ind_chk(7'h02, 24'h000000);
    ind_rd(7'h05, 1'b0, got);
    ind_chk(7'h05, 24'h000000);
    ind_rd(7'h08, 1'b0, got);
    ind_chk(7'h08, 24'h000000);
    // One line end restarts the running sums; the next line end closes after three ticks
    line_cycle_end = 1'b1;
    @(posedge meter_tick_ff);
    @(negedge ref_clk);
    line_cycle_end = 1'b0;
    @(posedge meter_tick_ff);
    @(posedge meter_tick_ff);
    @(negedge ref_clk);
    line_cycle_end = 1'b1;
    @(posedge meter_tick_ff);
    @(negedge ref_clk);
    line_cycle_end = 1'b0;
    ind_chk(7'h03, 24'h000030);
    ind_chk(7'h06, 24'hffffd0);
    ind_chk(7'h09, 24'h369d02);
    ind_wr(7'h0c, 24'h000049);
    ind_chk(7'h0a, 24'h000032);
    rd_chk(8'hd3, 8'h65);
    alt = 1'b1;
    rd_chk(8'hd2, 8'h43);
    rd_chk(8'hd1, 8'h21);
    rd_chk(8'hd3, 8'h13);
    wr(8'hd1, 8'hff);
    rd_chk(8'hd1, 8'h9b);
    rd_chk(8'hd6, 8'h12);
    rd_chk(8'hd4, 8'h56);
    rd_chk(8'he4, 8'h12);
    rd_chk(8'he2, 8'h56);
    rd_chk(8'he7, 8'h13);
    rd_chk(8'he6, 8'h57);
    rd_chk(8'h95, 8'h00);
    wr(8'hd9, 8'ha5);
    rd_chk(8'hd9, 8'ha5);
    irq_event = 24'h000201;
    @(negedge ref_clk);
    irq_event = 24'h000000;
    rd_chk(8'hdc, 8'h01);
    wr(8'hdc, 8'h01);
    rd_chk(8'hdc, 8'h00);
    rd_chk(8'hdd, 8'h02);
    rd_chk(8'hde, 8'h00);
    print_verdict();
  end
endmodule // testbench
